// *** verilog/cfr_flags_regs.v ***
// Functional notes
// RULE_01 - each flag is 1 when its condition is true, else 0
// RULE_02 - flags not affected by an operation keep their stored value
// RULE_03 - overflow set when carries out of bits 0 and 1 differ on add/sub/cmp/sla
// RULE_04 - overflow is sticky; the overflow test branch clears it
// RULE_05 - both subroutine returns may restore overflow to 1 or 0
// RULE_06 - console may clear overflow when not under program control
// RULE_07 - arithmetic and logic operations set zero flag from an all-zero result
// RULE_08 - minus flag copies bit 0 (msb) of the result
// RULE_09 - carry set on carry out of bit 0; borrow counts as carry
// RULE_10 - compare subtracts, updates all four flags, writes no register
// RULE_11 - flag loads derive flags from a memory operand or a working register
// RULE_12 - codes 0 and 1 read constants zero and one
// RULE_13 - code 2 is program register; address low bits, status in manual mode
// RULE_14 - code 3 accumulator, code 4 accumulator extension
// RULE_15 - codes 5-7 index registers; second one takes link address
// RULE_16 - arithmetic trap vectors to storage location 41 octal
// RULE_17 - multiply traps when accumulator holds the most negative value
// RULE_18 - divide traps when accumulator magnitude is at least divisor magnitude
// RULE_19 - floating exponent out of range raises the trap
// RULE_20 - trap instruction always raises the trap
// RULE_21 - writes to the constant codes are ignored
`timescale 1ns/10ps
`default_nettype none
`include "cfr_defines.vh"

module cfr_flags_regs #(
    parameter W = 24
) (
    input  wire          sys_clk,        // processor clock
    input  wire          rst,            // synchronous reset, active high
    input  wire          clk_en,         // freezes all state when low
    input  wire          op_valid,       // one-cycle operation strobe
    input  wire [3:0]    op_code,        // alu operation select
    input  wire [2:0]    src_sel,        // source register code
    input  wire [2:0]    dst_sel,        // destination register code
    input  wire [W-1:0]  mem_operand,    // operand from main storage
    input  wire          flt_exp_ovf,    // floating exponent out of range
    input  wire          wr_en,          // direct register write strobe
    input  wire [2:0]    wr_sel,         // direct write register code
    input  wire [W-1:0]  wr_data,        // direct write data
    input  wire          link_en,        // branch and link strobe
    input  wire [14:0]   link_addr,      // link address to store
    input  wire          pc_load,        // load program counter
    input  wire [14:0]   pc_next,        // next instruction address
    input  wire          ovf_test,       // overflow test branch executes
    input  wire          ret_restore,    // subroutine return restores overflow
    input  wire          ret_ovf_val,    // overflow value restored on return
    input  wire          console_clr,    // console overflow clear
    input  wire          manual_mode,    // not under program control
    input  wire          stop_st,        // stop status bit
    input  wire          malf_st,        // machine malfunction status bit
    input  wire [2:0]    rd_sel,         // read-port register code
    output reg  [W-1:0]  rd_data_r,      // read-port data
    output reg           flag_ovf_r,     // overflow condition flag
    output reg           flag_zero_r,    // zero condition flag
    output reg           flag_minus_r,   // minus condition flag
    output reg           flag_carry_r,   // carry condition flag
    output reg           trap_r,         // one-cycle trap pulse
    output reg  [14:0]   trap_vec_r,     // trap target address
    output reg  [W-1:0]  result_r        // last alu result
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    reg [W-1:0] regs_r [2:7];
    integer     i;

    // read mux; constants for codes 0 and 1
    function [W-1:0] rd_reg;
        input [2:0] sel;
        begin
            // RULE_12 constant sources
            if (sel == `CFR_SEL_ZERO)
                rd_reg = `CFR_CONST_ZERO;
            else if (sel == `CFR_SEL_ONE)
                rd_reg = `CFR_CONST_ONE;
            else
                rd_reg = regs_r[sel];
        end
    endfunction

    // RULE_18 magnitude for divide
    function [W-1:0] abs_val;
        input [W-1:0] v;
        begin
            abs_val = v[W-1] ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    // RULE_21 constant codes unwritable
    function wr_ok;
        input [2:0] sel;
        begin
            wr_ok = (sel != `CFR_SEL_ZERO) && (sel != `CFR_SEL_ONE);
        end
    endfunction

    // full-word adder with carry out
    function [W:0] add_full;
        input [W-1:0] a;
        input [W-1:0] b;
        input         cin;
        begin
            add_full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        end
    endfunction

    // carry out of bit 1 (msb first), i.e. into the msb
    function add_mid_carry;
        input [W-1:0] a;
        input [W-1:0] b;
        input         cin;
        reg   [W-1:0] t;
        begin
            t = {1'b0, a[W-2:0]} + {1'b0, b[W-2:0]} + {{(W-1){1'b0}}, cin};
            add_mid_carry = t[W-1];
        end
    endfunction

    // ------------------------------------------------------------
    // alu
    // ------------------------------------------------------------
    wire [W-1:0] src_v = rd_reg(src_sel);
    // RULE_14 accumulator operand
    wire [W-1:0] acc_v = regs_r[`CFR_SEL_ACC];
    // RULE_18 divisor in index two
    wire [W-1:0] idx2_v = regs_r[`CFR_SEL_IDX2];

    reg  [W:0]   sum_w;
    reg  [W-1:0] res_nxt;
    reg          c0_nxt;
    reg          c1_nxt;
    reg          upd_ovf;
    reg          upd_zm;
    reg          upd_c;
    reg          wr_res;
    reg          trap_nxt;

    always @*
    begin
        sum_w    = {(W+1){1'b0}};
        res_nxt  = acc_v;
        c0_nxt   = 1'b0;
        c1_nxt   = 1'b0;
        upd_ovf  = 1'b0;
        upd_zm   = 1'b0;
        upd_c    = 1'b0;
        wr_res   = 1'b0;
        trap_nxt = 1'b0;
        case (op_code)
            `CFR_OP_ADD:
            begin
                sum_w   = add_full(acc_v, src_v, 1'b0);
                c1_nxt  = add_mid_carry(acc_v, src_v, 1'b0);
                res_nxt = sum_w[W-1:0];
                // RULE_09 carry out of bit 0
                c0_nxt  = sum_w[W];
                upd_ovf = 1'b1;
                upd_zm  = 1'b1;
                upd_c   = 1'b1;
                wr_res  = 1'b1;
            end
            `CFR_OP_SUB, `CFR_OP_CMP:
            begin
                // RULE_10 compare is full subtract
                // two's complement subtract; borrow reported as carry
                sum_w   = add_full(acc_v, ~src_v, 1'b1);
                c1_nxt  = add_mid_carry(acc_v, ~src_v, 1'b1);
                res_nxt = sum_w[W-1:0];
                // RULE_09 carry on borrow
                c0_nxt  = ~sum_w[W];
                upd_ovf = 1'b1;
                upd_zm  = 1'b1;
                upd_c   = 1'b1;
                // RULE_10 compare discards difference
                wr_res  = (op_code == `CFR_OP_SUB);
            end
            `CFR_OP_SLA:
            begin
                res_nxt = {acc_v[W-2:0], 1'b0};
                // RULE_03 shifted-out carries
                c0_nxt  = acc_v[W-1];
                c1_nxt  = acc_v[W-2];
                upd_ovf = 1'b1;
                upd_zm  = 1'b1;
                wr_res  = 1'b1;
            end
            `CFR_OP_AND, `CFR_OP_OR, `CFR_OP_XOR:
            begin
                res_nxt = (op_code == `CFR_OP_AND) ? (acc_v & src_v) :
                          (op_code == `CFR_OP_OR)  ? (acc_v | src_v) : (acc_v ^ src_v);
                // RULE_07 logic sets zero
                upd_zm  = 1'b1;
                wr_res  = 1'b1;
            end
            // RULE_11 flags from operand
            `CFR_OP_MEMFLG, `CFR_OP_REGFLG:
            begin
                res_nxt = (op_code == `CFR_OP_MEMFLG) ? mem_operand : src_v;
                upd_zm  = 1'b1;
                upd_c   = 1'b1;
            end
            // RULE_17 most negative multiplicand
            `CFR_OP_MUL:
                trap_nxt = (acc_v == `CFR_MOST_NEG);
            // RULE_18 oversize numerator
            `CFR_OP_DIV:
                trap_nxt = (abs_val(acc_v) >= abs_val(idx2_v));
            // RULE_19 exponent out of range
            `CFR_OP_FLTCHK:
                trap_nxt = flt_exp_ovf;
            // RULE_20 trap instruction
            `CFR_OP_TRAP:
                trap_nxt = 1'b1;
            `CFR_OP_MOVE:
            begin
                res_nxt = src_v;
                wr_res  = 1'b1;
            end
            default:
                res_nxt = acc_v;
        endcase
    end

    // ------------------------------------------------------------
    // overflow detect
    // ------------------------------------------------------------
    reg ovf_hit;

    // RULE_03 carries differ
    always @*
    begin
        ovf_hit = 1'b0;
        case (op_code)
            `CFR_OP_ADD, `CFR_OP_SUB, `CFR_OP_CMP:
                // raw adder carry; on subtract the carry flag is its inverse, the borrow
                ovf_hit = sum_w[W] ^ c1_nxt;
            `CFR_OP_SLA:
                ovf_hit = c0_nxt ^ c1_nxt;
            default:
                ovf_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    reg flag_ovf_nxt;

    always @*
    begin
        // RULE_02 hold by default
        flag_ovf_nxt = flag_ovf_r;
        // RULE_06 console clear
        if (manual_mode && console_clr)
            flag_ovf_nxt = 1'b0;
        // RULE_04 test branch clears
        if (op_valid && ovf_test)
            flag_ovf_nxt = 1'b0;
        // RULE_05 return restore
        if (op_valid && ret_restore)
            flag_ovf_nxt = ret_ovf_val;
        // RULE_04 sticky set wins
        if (op_valid && upd_ovf && ovf_hit)
            flag_ovf_nxt = 1'b1;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            flag_ovf_r   <= 1'b0;
            flag_zero_r  <= 1'b0;
            flag_minus_r <= 1'b0;
            flag_carry_r <= 1'b0;
            trap_r       <= 1'b0;
            trap_vec_r   <= `CFR_TRAP_VEC;
            result_r     <= `CFR_REG_RST;
        end
        else if (clk_en)
        begin
            // RULE_01 flags hold truth
            flag_ovf_r <= flag_ovf_nxt;
            // RULE_02 untouched flags hold
            if (op_valid && upd_zm)
            begin
                // RULE_07 zero flag
                flag_zero_r  <= (res_nxt == {W{1'b0}});
                // RULE_08 minus flag
                flag_minus_r <= res_nxt[W-1];
            end
            // RULE_09 carry flag
            if (op_valid && upd_c)
                flag_carry_r <= (op_code == `CFR_OP_MEMFLG || op_code == `CFR_OP_REGFLG)
                                ? res_nxt[0] : c0_nxt;
            // RULE_20 one-cycle trap pulse
            trap_r     <= op_valid && trap_nxt;
            // RULE_16 trap vector
            trap_vec_r <= `CFR_TRAP_VEC;
            if (op_valid)
                result_r <= res_nxt;
        end
    end

    // ------------------------------------------------------------
    // register writes and read port
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (i = 2; i < 8; i = i + 1)
                regs_r[i] <= `CFR_REG_RST;
            rd_data_r <= `CFR_REG_RST;
        end
        else if (clk_en)
        begin
            // RULE_13 program counter load
            if (pc_load)
                regs_r[`CFR_SEL_PROG][14:0] <= pc_next;
            // RULE_21 constant codes ignore writes
            if (op_valid && wr_res && wr_ok(dst_sel))
                regs_r[dst_sel] <= res_nxt;
            // RULE_14 direct register write
            if (wr_en && wr_ok(wr_sel))
                regs_r[wr_sel] <= wr_data;
            // RULE_15 link into index two
            if (link_en)
                regs_r[`CFR_SEL_IDX2] <= {{(W-15){1'b0}}, link_addr};
            // RULE_12 read port
            rd_data_r <= rd_reg(rd_sel);
            // RULE_13 manual status display
            if (manual_mode && rd_sel == `CFR_SEL_PROG)
            begin
                rd_data_r[`CFR_ST_STOP]  <= stop_st;
                rd_data_r[`CFR_ST_MALF]  <= malf_st;
                rd_data_r[`CFR_ST_OVF]   <= flag_ovf_r;
                rd_data_r[`CFR_ST_ZERO]  <= flag_zero_r;
                rd_data_r[`CFR_ST_MINUS] <= flag_minus_r;
                rd_data_r[`CFR_ST_CARRY] <= flag_carry_r;
            end
        end
    end

endmodule // cfr_flags_regs

`default_nettype wire

// *** verilog/cfr_defines.vh ***
`ifndef CFR_DEFINES_VH
`define CFR_DEFINES_VH
// register select codes
`define CFR_SEL_ZERO    3'h0
`define CFR_SEL_ONE     3'h1
`define CFR_SEL_PROG    3'h2
`define CFR_SEL_ACC     3'h3
`define CFR_SEL_ACCX    3'h4
`define CFR_SEL_IDX1    3'h5
`define CFR_SEL_IDX2    3'h6
`define CFR_SEL_IDX3    3'h7
// reset values and constants
`define CFR_REG_RST     24'h000000
`define CFR_CONST_ZERO  24'h000000
`define CFR_CONST_ONE   24'h000001
`define CFR_MOST_NEG    24'h800000
// trap vector, 41 octal
`define CFR_TRAP_VEC    15'h0021
// alu operation codes
`define CFR_OP_NONE     4'h0
`define CFR_OP_ADD      4'h1
`define CFR_OP_SUB      4'h2
`define CFR_OP_CMP      4'h3
`define CFR_OP_SLA      4'h4
`define CFR_OP_AND      4'h5
`define CFR_OP_OR       4'h6
`define CFR_OP_XOR      4'h7
`define CFR_OP_MEMFLG   4'h8
`define CFR_OP_REGFLG   4'h9
`define CFR_OP_MUL      4'ha
`define CFR_OP_DIV      4'hb
`define CFR_OP_TRAP     4'hc
`define CFR_OP_FLTCHK   4'hd
`define CFR_OP_MOVE     4'he
// status field positions in program register (bit 23 = msb)
`define CFR_ST_STOP     23
`define CFR_ST_MALF     22
`define CFR_ST_OVF      21
`define CFR_ST_ZERO     20
`define CFR_ST_MINUS    19
`define CFR_ST_CARRY    18
`endif

// *** testbench/cfr_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cfr_defines.vh"
module cfr_checker #(
    parameter W = 24
) (
    input wire logic         sys_clk,      // clock
    input wire logic         rst,          // reset
    input wire logic         clk_en,       // run
    input wire logic         op_valid,     // op strobe
    input wire logic [3:0]   op_code,      // op
    input wire logic         ovf_test,     // ovf test
    input wire logic         ret_restore,  // restore
    input wire logic         ret_ovf_val,  // value
    input wire logic         console_clr,  // console
    input wire logic         manual_mode,  // manual
    input wire logic [2:0]   rd_sel,       // read code
    input wire logic [W-1:0] rd_data_r,    // read data
    input wire logic         flag_ovf_r,   // O
    input wire logic         flag_zero_r,  // Z
    input wire logic         flag_minus_r, // M
    input wire logic         flag_carry_r, // C
    input wire logic         trap_r,       // trap
    input wire logic [14:0]  trap_vec_r,   // vector
    input wire logic [W-1:0] result_r      // result
);
    wire logic go = clk_en && op_valid;
    wire logic alu = go && op_code inside {`CFR_OP_ADD, `CFR_OP_SUB, `CFR_OP_AND, `CFR_OP_OR, `CFR_OP_XOR};
    wire logic nop = go && op_code == `CFR_OP_NONE;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_trap_instr: assert property (
        go && op_code == `CFR_OP_TRAP |=> trap_r) else $error("trap op gave no pulse");
    a_trap_vector: assert property (
        trap_vec_r == `CFR_TRAP_VEC) else $error("trap vector wrong");
    a_ovf_sticky: assert property (
        flag_ovf_r && !(go && (ovf_test || ret_restore)) && !(clk_en && console_clr && manual_mode)
        |=> flag_ovf_r) else $error("overflow dropped");
    a_ovf_test_clr: assert property (
        nop && ovf_test && !ret_restore |=> !flag_ovf_r) else $error("overflow test kept flag");
    a_ret_restore: assert property (
        nop && ret_restore |=> flag_ovf_r == $past(ret_ovf_val)) else $error("restore wrong");
    a_console_clr: assert property (
        clk_en && console_clr && manual_mode && !op_valid |=> !flag_ovf_r) else $error("console clear");
    a_zero_flag: assert property (
        alu |=> flag_zero_r == (result_r == '0)) else $error("zero flag wrong");
    a_minus_flag: assert property (
        alu |=> flag_minus_r == result_r[W-1]) else $error("minus flag wrong");
    a_flags_hold: assert property (
        !op_valid |=> $stable({flag_zero_r, flag_minus_r, flag_carry_r})) else $error("flags moved");
    a_const_zero: assert property (
        clk_en && rd_sel == `CFR_SEL_ZERO |=> rd_data_r == '0) else $error("zero source");
    a_const_one: assert property (
        clk_en && rd_sel == `CFR_SEL_ONE |=> rd_data_r == 1) else $error("one source");
    a_freeze_hold: assert property (
        !clk_en |=> $stable({flag_ovf_r, flag_zero_r, flag_minus_r, flag_carry_r, trap_r, result_r, rd_data_r}))
        else $error("state moved while clock enable low");
    c_trap: cover property (trap_r);
    c_freeze: cover property (!clk_en && op_valid);
    c_ovf_set: cover property ($rose(flag_ovf_r));
    c_compare: cover property (go && op_code == `CFR_OP_CMP);
endmodule // cfr_checker
bind cfr_flags_regs cfr_checker #(.W(W)) i_chk (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .op_valid(op_valid), .op_code(op_code), .ovf_test(ovf_test), .ret_restore(ret_restore),
    .ret_ovf_val(ret_ovf_val), .console_clr(console_clr), .manual_mode(manual_mode), .rd_sel(rd_sel),
    .rd_data_r(rd_data_r), .flag_ovf_r(flag_ovf_r), .flag_zero_r(flag_zero_r),
    .flag_minus_r(flag_minus_r), .flag_carry_r(flag_carry_r), .trap_r(trap_r),
    .trap_vec_r(trap_vec_r), .result_r(result_r));
`default_nettype wire

// *** testbench/cfr_storage_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfr_storage_model (
    input  wire logic [1:0]  addr,     // word address
    output wire logic [23:0] mem_word  // storage word
);
    // word 1 is negative with lsb set, the rest read as zero
    assign mem_word = (addr == 2'h1) ? 24'h800001 : 24'h000000;
endmodule // cfr_storage_model
`default_nettype wire

// *** testbench/tb_cpu_flags_registers_trap.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cfr_defines.vh"
module tb_cpu_flags_registers_trap;
    logic        sys_clk = 0, rst = 1, op_valid = 0, wr_en = 0, link_en = 0, pc_load = 0;
    logic        ovf_test = 0, ret_restore = 0, ret_ovf_val = 0, console_clr = 0, manual_mode = 0;
    logic        stop_st = 1, malf_st = 0, clk_en = 1, flt_exp_ovf = 0, trap_r;
    logic        flag_ovf_r, flag_zero_r, flag_minus_r, flag_carry_r;
    logic [3:0]  op_code = 0;
    logic [2:0]  src_sel = 0, dst_sel = 0, wr_sel = 0, rd_sel = 0;
    logic [1:0]  mem_addr = 0;
    logic [14:0] link_addr = 0, pc_next = 0, trap_vec_r;
    logic [23:0] wr_data = 0, mem_operand, rd_data_r, result_r;
    int          error_cnt = 0, num_checks = 0;
    always #2 sys_clk = ~sys_clk;
    cfr_storage_model i_mem (.addr(mem_addr), .mem_word(mem_operand));
    cfr_flags_regs #(.W(24)) i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
        .op_code(op_code), .src_sel(src_sel), .dst_sel(dst_sel), .mem_operand(mem_operand),
        .flt_exp_ovf(flt_exp_ovf), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
        .link_en(link_en), .link_addr(link_addr), .pc_load(pc_load), .pc_next(pc_next),
        .ovf_test(ovf_test), .ret_restore(ret_restore), .ret_ovf_val(ret_ovf_val),
        .console_clr(console_clr), .manual_mode(manual_mode), .stop_st(stop_st), .malf_st(malf_st),
        .rd_sel(rd_sel), .rd_data_r(rd_data_r), .flag_ovf_r(flag_ovf_r), .flag_zero_r(flag_zero_r),
        .flag_minus_r(flag_minus_r), .flag_carry_r(flag_carry_r), .trap_r(trap_r),
        .trap_vec_r(trap_vec_r), .result_r(result_r));
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [23:0] flg();
        return {20'h0, flag_ovf_r, flag_zero_r, flag_minus_r, flag_carry_r};
    endfunction
    task automatic op(input logic [3:0] c, input logic [2:0] s, input logic [2:0] d, input logic [2:0] ctl);
        @(posedge sys_clk);
        op_valid <= 1;
        op_code <= c;
        src_sel <= s;
        dst_sel <= d;
        {ovf_test, ret_restore, ret_ovf_val} <= ctl;
        @(posedge sys_clk);
        op_valid <= 0;
        {ovf_test, ret_restore, ret_ovf_val} <= 3'h0;
        #1;
    endtask
    task automatic wr(input logic [2:0] s, input logic [23:0] v);
        @(posedge sys_clk);
        wr_en <= 1;
        wr_sel <= s;
        wr_data <= v;
        @(posedge sys_clk);
        wr_en <= 0;
    endtask
    task automatic rd(input logic [2:0] s, input logic [23:0] exp);
        @(posedge sys_clk);
        rd_sel <= s;
        @(posedge sys_clk);
        #1;
        chk(rd_data_r, exp);
    endtask
    task automatic con(input logic m);
        @(posedge sys_clk);
        manual_mode <= m;
        console_clr <= 1;
        @(posedge sys_clk);
        console_clr <= 0;
        #1;
    endtask
    task automatic t_regs();
        for (int i = 0; i < 8; i++)
            if (i != 2)
                wr(3'(i), 24'h5a0000 + 24'(i));
        rd(3'h0, `CFR_CONST_ZERO);
        rd(3'h1, `CFR_CONST_ONE);
        for (int i = 3; i < 8; i++)
            rd(3'(i), 24'h5a0000 + 24'(i));
        @(posedge sys_clk);
        link_en <= 1;
        link_addr <= 15'h4321;
        pc_load <= 1;
        pc_next <= 15'h1234;
        @(posedge sys_clk);
        link_en <= 0;
        pc_load <= 0;
        rd(3'h6, 24'h004321);
        rd(3'h2, 24'h001234);
    endtask
    task automatic t_flags();
        wr(3'h3, 24'h7fffff);
        wr(3'h5, 24'h000001);
        op(`CFR_OP_ADD, 3'h5, 3'h3, 3'h0);
        chk(flg(), 24'h00000a);
        rd(3'h3, 24'h800000);
        wr(3'h3, 24'hffffff);
        op(`CFR_OP_ADD, 3'h5, 3'h3, 3'h0);
        chk(flg(), 24'h00000d);
        op(`CFR_OP_NONE, 3'h0, 3'h0, 3'h4);
        chk(flg(), 24'h000005);
        wr(3'h3, 24'h400000);
        op(`CFR_OP_SLA, 3'h3, 3'h3, 3'h0);
        chk(flg(), 24'h00000b);
        op(`CFR_OP_NONE, 3'h0, 3'h0, 3'h2);
        chk(flg(), 24'h000003);
        op(`CFR_OP_NONE, 3'h0, 3'h0, 3'h3);
        chk(flg(), 24'h00000b);
        con(0);
        chk(flg(), 24'h00000b);
        con(1);
        chk(flg(), 24'h000003);
        rd(3'h2, 24'h8c1234);
        @(posedge sys_clk);
        stop_st <= 0;
        malf_st <= 1;
        rd(3'h2, 24'h4c1234);
        con(0);
    endtask
    task automatic t_cmp();
        wr(3'h3, 24'h000007);
        wr(3'h5, 24'h000005);
        op(`CFR_OP_CMP, 3'h5, 3'h3, 3'h0);
        chk(flg(), 24'h000000);
        rd(3'h3, 24'h000007);
        op(`CFR_OP_SUB, 3'h5, 3'h3, 3'h0);
        op(`CFR_OP_CMP, 3'h5, 3'h3, 3'h0);
        chk(flg(), 24'h000003);
        op(`CFR_OP_XOR, 3'h3, 3'h3, 3'h0);
        chk(flg(), 24'h000005);
        mem_addr <= 2'h1;
        op(`CFR_OP_MEMFLG, 3'h0, 3'h0, 3'h0);
        chk(flg(), 24'h000003);
        op(`CFR_OP_REGFLG, 3'h1, 3'h0, 3'h0);
        chk(flg(), 24'h000001);
    endtask
    task automatic t_trap(input logic [3:0] c, input logic [23:0] a, input logic [23:0] x, input logic f,
                          input logic exp);
        wr(3'h3, a);
        wr(3'h6, x);
        flt_exp_ovf <= f;
        op(c, 3'h6, 3'h3, 3'h0);
        chk({23'h0, trap_r}, {23'h0, exp});
        chk({9'h0, trap_vec_r}, 24'h000021);
        @(posedge sys_clk);
        #1;
        chk({23'h0, trap_r}, 24'h0);
    endtask
    task automatic t_freeze();
        @(posedge sys_clk);
        clk_en <= 0;
        op(`CFR_OP_ADD, 3'h1, 3'h3, 3'h0);
        chk(flg(), 24'h000001);
        chk(result_r, 24'h000000);
        @(posedge sys_clk);
        clk_en <= 1;
        rd(3'h3, 24'h000000);
    endtask
    task automatic t_logic();
        op(`CFR_OP_ADD, 3'h1, 3'h3, 3'h0);
        chk(result_r, 24'h000001);
        op(`CFR_OP_OR, 3'h5, 3'h3, 3'h0);
        chk(result_r, 24'h000005);
        op(`CFR_OP_AND, 3'h0, 3'h3, 3'h0);
        chk(flg(), 24'h000004);
        op(`CFR_OP_MOVE, 3'h5, 3'h4, 3'h0);
        chk(flg(), 24'h000004);
        rd(3'h4, 24'h000005);
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 0;
        t_regs();
        t_flags();
        t_cmp();
        t_trap(`CFR_OP_MUL, 24'h800000, 24'h3, 0, 1);
        t_trap(`CFR_OP_MUL, 24'h7fffff, 24'h3, 0, 0);
        t_trap(`CFR_OP_DIV, 24'hfffffd, 24'h3, 0, 1);
        t_trap(`CFR_OP_DIV, 24'h2, 24'hfffffd, 0, 0);
        t_trap(`CFR_OP_FLTCHK, 24'h0, 24'h0, 1, 1);
        t_trap(`CFR_OP_FLTCHK, 24'h0, 24'h0, 0, 0);
        t_trap(`CFR_OP_TRAP, 24'h0, 24'h0, 0, 1);
        t_freeze();
        t_logic();
        complete_run();
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end
endmodule // tb_cpu_flags_registers_trap
`default_nettype wire
